// >>> design/acs_serial_port.sv
// Serial output port of a converter that drives its own serial clock.
`timescale 1ns/100ps

module acs_serial_port #(
  parameter int unsigned ADDR_W   = acs_pkg::ADDR_BITS,
  parameter int unsigned SCK_HALF = acs_pkg::SCK_HALF_CYC,
  parameter int unsigned TEST_CYC = acs_pkg::TEST_CYC
) (
  // Core clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Link oscillator clock.
  input  wire logic                 osc_clk_i,
  // Converter core side.
  input  wire logic                 res_valid_i,
  input  wire logic                 res_sign_i,
  input  wire logic [15:0]          res_data_i,
  output logic                      conv_start_o,
  output logic [ADDR_W-1:0]         chan_addr_o,
  output logic                      int_sck_mode_o,
  // Serial pins.
  input  wire logic                 cs_n_i,
  input  wire logic                 sdi_i,
  input  wire logic                 sck_i,
  output logic                      sck_o,
  output logic                      sck_oe_o,
  output logic                      sck_pu_o,
  output logic                      sdo_o,
  output logic                      sdo_oe_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [acs_pkg::CNT_W-1:0] HALF_LAST =
    acs_pkg::CNT_W'(SCK_HALF - 1);
  localparam logic [acs_pkg::CNT_W-1:0] TEST_LAST =
    acs_pkg::CNT_W'(TEST_CYC - 1);
  localparam logic [4:0] ADDR_CNT = 5'(ADDR_W);
  localparam logic [1:0] POR_LAST = 2'(acs_pkg::POR_CYC);

  logic                         lrst_q1, lrst;
  logic                         cs_m, cs_s, cs_d;
  logic                         sck_m, sck_s;
  logic                         sdi_m, sdi_s;
  logic                         dn_m, dn_s, dn_d;
  logic                         st_m, st_s, st_d;
  logic                         md_m, md_s;
  logic [1:0]                   por_cnt_r;
  logic                         por_done_r;
  logic                         int_mode_r;
  logic                         cont_r;
  logic                         busy_r;
  logic                         start_tgl_r;
  logic                         done_tgl_r;
  logic [16:0]                  hold_r;
  acs_pkg::acs_state_t          st_r;
  logic [acs_pkg::CNT_W-1:0]    cnt_r;
  logic [4:0]                   bit_cnt_r;
  logic [acs_pkg::FRAME_BITS-1:0] shf_r;
  logic [ADDR_W-1:0]            addr_sh_r;
  logic [ADDR_W-1:0]            addr_r;
  logic                         rearm_r;
  logic                         sck_r, sck_oe_r, pu_r, sdo_r, sdo_oe_r;
  logic                         cs_fall, active, cont_act, done_evt;
  logic                         half_done, shifting;
  logic                         rise_now, fall_now, finish_now, abort_now;
  logic                         por_start, start_now, sdo_nxt;

  // Builds a frame from a held result, done flag first.
  function automatic logic [acs_pkg::FRAME_BITS-1:0] make_frame(
    input logic [16:0] res
  );
    logic [acs_pkg::FRAME_BITS-1:0] f;
    f = '0;
    f[acs_pkg::FRM_EOC_POS]  = 1'b0;
    f[acs_pkg::FRM_ZERO_POS] = 1'b0;
    f[acs_pkg::FRM_SIGN_POS] = res[16];
    f[acs_pkg::RESULT_BITS-1:0] = res[15:0];
    return f;
  endfunction : make_frame

  // ----------------------------------------------------------------
  // Link domain reset and pin synchronisers
  // ----------------------------------------------------------------
  // Reset enters the link domain at once and leaves it after two edges.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_q1 <= 1'b1;
      lrst    <= 1'b1;
    end else begin
      lrst_q1 <= 1'b0;
      lrst    <= lrst_q1;
    end
  end

  // Pins pass two flip-flops; cs_d only delays the settled level.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_m  <= 1'b1;
      cs_s  <= 1'b1;
      cs_d  <= 1'b1;
      sck_m <= acs_pkg::SCK_RST;
      sck_s <= acs_pkg::SCK_RST;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
    end else begin
      cs_m  <= cs_n_i;
      cs_s  <= cs_m;
      cs_d  <= cs_s;
      sck_m <= sck_i;
      sck_s <= sck_m;
      sdi_m <= sdi_i;
      sdi_s <= sdi_m;
    end
  end

  // Done toggle from the core domain, synchronised then edge detected.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dn_m <= 1'b0;
      dn_s <= 1'b0;
      dn_d <= 1'b0;
    end else begin
      dn_m <= done_tgl_r;
      dn_s <= dn_m;
      dn_d <= dn_s;
    end
  end

  // ----------------------------------------------------------------
  // Link domain decode
  // ----------------------------------------------------------------
  // Events and qualifiers for the serial state machine.
  // A select fall seen during power-on settling must not drive the pin,
  // or the clock level sampled for the power-on mode choice is spoiled.
  assign cs_fall    = cs_d & ~cs_s & por_done_r;
  // The mode is re-chosen at a select fall, so nothing acts on the old one.
  assign active     = int_mode_r & ~cs_s & ~cs_fall;
  assign cont_act   = cont_r & active;
  assign done_evt   = dn_s ^ dn_d;
  assign half_done  = (cnt_r == HALF_LAST);
  assign shifting   = (st_r == acs_pkg::ACS_HI) | (st_r == acs_pkg::ACS_LO);
  assign abort_now  = shifting & cs_s;
  assign finish_now = (st_r == acs_pkg::ACS_HI) & ~cs_s & half_done &
                      (bit_cnt_r == acs_pkg::FRAME_LAST);
  assign fall_now   = (st_r == acs_pkg::ACS_HI) & ~cs_s & half_done &
                      (bit_cnt_r != acs_pkg::FRAME_LAST);
  assign rise_now   = ((st_r == acs_pkg::ACS_SLEEP) & half_done) |
                      ((st_r == acs_pkg::ACS_TEST) & active &
                       (cnt_r == TEST_LAST)) |
                      ((st_r == acs_pkg::ACS_LO) & ~cs_s & half_done);
  assign por_start  = ~por_done_r & (por_cnt_r == POR_LAST);
  assign start_now  = por_start | finish_now | abort_now;
  assign sdo_nxt    = shifting ? shf_r[acs_pkg::FRAME_BITS-1] : busy_r;

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  // Power-on settle counter, then the clock pin level picks the mode.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      por_cnt_r  <= 2'h0;
      por_done_r <= 1'b0;
      int_mode_r <= 1'b0;
      cont_r     <= 1'b0;
    end else if (lrst) begin
      por_cnt_r  <= 2'h0;
      por_done_r <= 1'b0;
      int_mode_r <= 1'b0;
      cont_r     <= 1'b0;
    end else if (por_start) begin
      por_done_r <= 1'b1;
      int_mode_r <= sck_s;
      cont_r     <= sck_s & ~cs_s;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + 2'h1;
    end else if (cs_fall) begin
      int_mode_r <= sck_s;
      cont_r     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion status and start toggle
  // ----------------------------------------------------------------
  // Busy is the active-low done flag; the frame loads when done arrives.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r      <= 1'b1;
      start_tgl_r <= 1'b0;
    end else if (lrst) begin
      busy_r      <= 1'b1;
      start_tgl_r <= 1'b0;
    end else if (start_now) begin
      busy_r      <= 1'b1;
      start_tgl_r <= ~start_tgl_r;
    end else if (done_evt) begin
      busy_r      <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial state machine
  // ----------------------------------------------------------------
  // Sequences status test, sleep, and the nineteen clock cycles.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r      <= acs_pkg::ACS_CONV;
      cnt_r     <= '0;
      bit_cnt_r <= 5'h00;
      sck_r     <= acs_pkg::SCK_RST;
      sck_oe_r  <= 1'b0;
    end else if (lrst) begin
      st_r      <= acs_pkg::ACS_CONV;
      cnt_r     <= '0;
      bit_cnt_r <= 5'h00;
      sck_r     <= acs_pkg::SCK_RST;
      sck_oe_r  <= 1'b0;
    end else if (abort_now || finish_now) begin
      st_r      <= acs_pkg::ACS_CONV;
      cnt_r     <= '0;
      bit_cnt_r <= 5'h00;
      sck_r     <= 1'b1;
      sck_oe_r  <= finish_now;
    end else if (rise_now) begin
      st_r      <= acs_pkg::ACS_HI;
      cnt_r     <= '0;
      bit_cnt_r <= bit_cnt_r + 5'h01;
      sck_r     <= 1'b1;
      sck_oe_r  <= 1'b1;
    end else if (fall_now) begin
      st_r      <= acs_pkg::ACS_LO;
      cnt_r     <= '0;
      sck_r     <= 1'b0;
    end else begin
      unique case (st_r)
        acs_pkg::ACS_CONV: begin
          cnt_r <= '0;
          if (cont_act && !busy_r) begin
            st_r     <= acs_pkg::ACS_SLEEP;
            sck_r    <= 1'b0;
            sck_oe_r <= 1'b1;
          end else if (active && !busy_r) begin
            st_r     <= acs_pkg::ACS_TEST;
            sck_r    <= 1'b0;
            sck_oe_r <= 1'b1;
          end else if (cont_act) begin
            sck_r    <= 1'b1;
            sck_oe_r <= 1'b1;
          end else if (cs_fall) begin
            sck_r    <= 1'b0;
            sck_oe_r <= sck_s;
          end else if (!active) begin
            sck_oe_r <= 1'b0;
          end
        end
        acs_pkg::ACS_TEST: begin
          if (!active) begin
            st_r     <= acs_pkg::ACS_CONV;
            sck_oe_r <= 1'b0;
          end else begin
            cnt_r    <= cnt_r + 1'b1;
          end
        end
        acs_pkg::ACS_SLEEP: cnt_r <= cnt_r + 1'b1;
        acs_pkg::ACS_HI:    cnt_r <= cnt_r + 1'b1;
        acs_pkg::ACS_LO:    cnt_r <= cnt_r + 1'b1;
        default:            st_r  <= acs_pkg::ACS_CONV;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift register and address capture
  // ----------------------------------------------------------------
  // Result loads on done and moves one place on each falling edge.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shf_r <= '0;
    end else if (lrst) begin
      shf_r <= '0;
    end else if (done_evt) begin
      shf_r <= make_frame(hold_r);
    end else if (fall_now) begin
      shf_r <= {shf_r[acs_pkg::FRAME_BITS-2:0], 1'b1};
    end
  end

  // Address bits enter on rising edges; only a full set is committed.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_sh_r <= '0;
      addr_r    <= ADDR_W'(acs_pkg::ADDR_RST);
    end else if (lrst) begin
      addr_sh_r <= '0;
      addr_r    <= ADDR_W'(acs_pkg::ADDR_RST);
    end else begin
      if (rise_now && bit_cnt_r < ADDR_CNT) begin
        addr_sh_r <= {addr_sh_r[ADDR_W-2:0], sdi_s};
      end
      if ((finish_now || abort_now) && bit_cnt_r >= ADDR_CNT) begin
        addr_r <= addr_sh_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin output registers
  // ----------------------------------------------------------------
  // Pull-up follows the pin level, re-armed after a status pulse.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rearm_r <= 1'b0;
    end else if (lrst) begin
      rearm_r <= 1'b0;
    end else if ((st_r == acs_pkg::ACS_TEST) && cs_s) begin
      rearm_r <= 1'b1;
    end else if (sck_s || cs_fall) begin
      rearm_r <= 1'b0;
    end
  end

  // Pull-up and data pin drivers come straight from these flip-flops; the clock pin drivers come from sck_r and sck_oe_r.
  always_ff @(posedge osc_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pu_r     <= 1'b1;
      sdo_r    <= 1'b1;
      sdo_oe_r <= 1'b0;
    end else begin
      pu_r     <= sck_s | rearm_r;
      sdo_r    <= sdo_nxt;
      sdo_oe_r <= ~cs_s & ~lrst;
    end
  end

  assign sck_o    = sck_r;
  assign sck_oe_o = sck_oe_r;
  assign sck_pu_o = pu_r;
  assign sdo_o    = sdo_r;
  assign sdo_oe_o = sdo_oe_r;

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  // Result is held stable, then announced by a toggle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_r     <= 17'h00000;
      done_tgl_r <= 1'b0;
    end else if (res_valid_i) begin
      hold_r     <= {res_sign_i, res_data_i};
      done_tgl_r <= ~done_tgl_r;
    end
  end

  // Start toggle and mode level cross in through two flip-flops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_m           <= 1'b0;
      st_s           <= 1'b0;
      st_d           <= 1'b0;
      md_m           <= 1'b0;
      md_s           <= 1'b0;
      conv_start_o   <= 1'b0;
      chan_addr_o    <= ADDR_W'(acs_pkg::ADDR_RST);
      int_sck_mode_o <= 1'b0;
    end else begin
      st_m           <= start_tgl_r;
      st_s           <= st_m;
      st_d           <= st_s;
      md_m           <= int_mode_r;
      md_s           <= md_m;
      conv_start_o   <= st_s ^ st_d;
      int_sck_mode_o <= md_s;
      if (st_s ^ st_d) begin
        chan_addr_o  <= addr_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SDO_HIZ: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    cs_s |=> !sdo_oe_o)
    else $error("data output driven while deselected");

  AST_TEST_LOW: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    (st_r == acs_pkg::ACS_TEST) |-> (sck_oe_o && !sck_o && !busy_r))
    else $error("clock not held low during status test");

  AST_TEST_DELAY: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    (st_r == acs_pkg::ACS_TEST) && (cnt_r != TEST_LAST)
      |=> (st_r != acs_pkg::ACS_HI))
    else $error("output began before status-test delay");

  AST_TEST_EXIT: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    (st_r == acs_pkg::ACS_TEST) && cs_s
      |=> (st_r == acs_pkg::ACS_CONV) && !busy_r && $stable(shf_r))
    else $error("result lost on early deselect");

  AST_FINISH: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    finish_now |=> sck_o && sck_oe_o && busy_r ##1 sdo_o)
    else $error("frame end did not raise clock and data");

  AST_ABORT: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    shifting && cs_s && !start_tgl_r |=> start_tgl_r && busy_r)
    else $error("abort did not start a conversion");

  AST_ADDR_KEEP: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    $changed(addr_r) |-> $past(bit_cnt_r) >= ADDR_CNT)
    else $error("partial address committed");

  AST_PU_OFF: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    !sck_s && !rearm_r |=> !sck_pu_o)
    else $error("pull-up on while clock pin low");

  AST_CONT_HIGH: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    cont_act && busy_r && (st_r == acs_pkg::ACS_CONV) && !done_evt
      |=> ##1 sck_o && sdo_o)
    else $error("continuous mode not high while converting");

  AST_SLEEP_MIN: assert property (
    @(posedge osc_clk_i) disable iff (lrst)
    $rose(st_r == acs_pkg::ACS_SLEEP)
      |-> (st_r == acs_pkg::ACS_SLEEP)[*4])
    else $error("continuous sleep shorter than half period");

endmodule : acs_serial_port

// >>> shared/acs_pkg.sv
// Constants and types shared by the internally clocked serial port.
package acs_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS   = 19;
  localparam int unsigned RESULT_BITS  = 16;
  localparam int unsigned ADDR_BITS    = 5;
  // Bit positions inside the frame, counted from the last bit sent.
  localparam int unsigned FRM_EOC_POS  = 18;
  localparam int unsigned FRM_ZERO_POS = 17;
  localparam int unsigned FRM_SIGN_POS = 16;
  localparam logic [4:0]  FRAME_LAST   = 5'h13;

  // ----------------------------------------------------------------
  // Timing, in the link oscillator domain
  // ----------------------------------------------------------------
  localparam int unsigned LINK_PERIOD_NS = 64;
  localparam int unsigned TEST_DELAY_NS  = 23000;
  // Least time, so it rounds up to whole oscillator cycles.
  localparam int unsigned TEST_CYC =
    (TEST_DELAY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  // Half period of the generated serial clock, in oscillator cycles.
  localparam int unsigned SCK_HALF_CYC = 4;
  localparam int unsigned CNT_W        = 9;
  localparam int unsigned POR_CYC      = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       SCK_RST      = 1'b1;
  localparam logic [4:0] ADDR_RST     = 5'h00;

  // Serial port states.
  typedef enum logic [2:0] {
    ACS_CONV,
    ACS_TEST,
    ACS_SLEEP,
    ACS_HI,
    ACS_LO
  } acs_state_t;

endpackage : acs_pkg

// >>> bench/acs_host_model.sv
// Host controller model that receives the generated serial clock.
`timescale 1ns/100ps
module acs_host_model (
  // Bench controls.
  input  wire logic        cs_n_i,
  input  wire logic        drv_low_i,
  input  wire logic        clr_i,
  input  wire logic [4:0]  addr_i,
  // Device pins.
  input  wire logic        sck_o,
  input  wire logic        sck_oe_o,
  input  wire logic        sck_pu_o,
  input  wire logic        sdo_o,
  output logic             sck_w_o,
  output logic             sdi_o,
  output logic [18:0]      frame_o,
  output logic [4:0]       edges_o
);
  logic [4:0] idx_r = 5'h00;

  // pin level; an undriven pin without pull-up keeps its charge.
  initial sck_w_o = 1'b1;
  always @(sck_o, sck_oe_o, sck_pu_o, drv_low_i) begin
    if (sck_oe_o === 1'b1) sck_w_o = sck_o;
    else if (drv_low_i) sck_w_o = 1'b0;
    else if (sck_pu_o === 1'b1) sck_w_o = 1'b1;
  end

  // capture one bit on each rising edge, nineteen at most.
  always @(posedge sck_w_o or posedge clr_i) begin
    if (clr_i) begin
      edges_o <= 5'h00;
      frame_o <= 19'h00000;
    end else if (!cs_n_i && edges_o < 5'h13) begin
      edges_o <= edges_o + 5'h01;
      frame_o <= {frame_o[17:0], sdo_o};
    end
  end

  // address moves on falling edges, so rising edges see it settled.
  always @(negedge sck_w_o or posedge clr_i) begin
    if (clr_i) idx_r <= 5'h00;
    else idx_r <= edges_o;
  end
  assign sdi_o = (idx_r < 5'h05) ? addr_i[3'h4 - idx_r[2:0]] : ~idx_r[0];
endmodule : acs_host_model

// >>> bench/test_adc_internal_clock_serial_port.sv
// Self-checking bench for the internally clocked serial port.
`timescale 1ns/100ps
module test_adc_internal_clock_serial_port;
  typedef struct packed {
    logic [4:0]  addr;
    logic        sign;
    logic [15:0] data;
    logic [18:0] frame;
  } acs_row_t;
  logic        clk_i, rst_i, osc_clk_i, res_valid_i, res_sign_i, cs_n_i;
  logic        drv_low, clr, conv_start_o, int_sck_mode_o, sck_o, sck_oe_o;
  logic        sck_pu_o, sdo_o, sdo_oe_o, sck_w, sdi;
  logic [15:0] res_data_i;
  logic [4:0]  chan_addr_o, addr, edges;
  logic [18:0] frame;
  int          err_count = 0, checked = 0, cycles = 0, starts, i, k;
  acs_row_t    rows [4] = '{
    '{5'h1f, 1'b1, 16'hffff, 19'h1ffff},
    '{5'h00, 1'b0, 16'h0000, 19'h00000},
    '{5'h15, 1'b1, 16'h8001, 19'h18001},
    '{5'h0a, 1'b0, 16'h7ffe, 19'h07ffe}};

  acs_serial_port #(.TEST_CYC(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .osc_clk_i(osc_clk_i),
    .res_valid_i(res_valid_i), .res_sign_i(res_sign_i),
    .res_data_i(res_data_i), .conv_start_o(conv_start_o),
    .chan_addr_o(chan_addr_o), .int_sck_mode_o(int_sck_mode_o),
    .cs_n_i(cs_n_i), .sdi_i(sdi), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sck_pu_o(sck_pu_o), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o));
  acs_host_model host (
    .cs_n_i(cs_n_i), .drv_low_i(drv_low), .clr_i(clr), .addr_i(addr),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sck_pu_o(sck_pu_o),
    .sdo_o(sdo_o), .sck_w_o(sck_w), .sdi_o(sdi), .frame_o(frame),
    .edges_o(edges));

  // Core clock and unrelated link clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    osc_clk_i = 1'b0;
    #7;
    forever #32 osc_clk_i = ~osc_clk_i;
  end

  // Counts conversion starts and cuts a hang short.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) starts <= 0;
    else if (conv_start_o === 1'b1) starts <= starts + 1;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic wait_start(input int n, input logic [4:0] exp);
    for (k = 0; k < 400 && starts < n; k++) @(posedge clk_i);
    tick(2);
    check(chan_addr_o, exp);
  endtask : wait_start

  task automatic give(input logic s, input logic [15:0] d);
    res_sign_i <= s;
    res_data_i <= d;
    res_valid_i <= 1'b1;
    @(posedge clk_i);
    res_valid_i <= 1'b0;
    tick(8);
  endtask : give

  task automatic open_frame(input logic [4:0] a, input logic cs);
    addr <= a;
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    cs_n_i <= cs;
  endtask : open_frame

  // Waits for nineteen edges, then the conversion flag.
  task automatic finish(input logic [18:0] exp);
    for (k = 0; k < 900 && edges < 5'h13; k++) @(posedge clk_i);
    check(frame, exp);
    for (k = 0; k < 20 && sdo_o !== 1'b1; k++) @(posedge clk_i);
    check({sck_oe_o, sck_o, sdo_o}, 3'b111);
  endtask : finish

  task automatic frame_run(input logic [4:0] a, input logic [18:0] exp);
    open_frame(a, 1'b0);
    for (k = 0; k < 20 && sdo_oe_o !== 1'b1; k++) @(posedge clk_i);
    @(posedge clk_i);
    check({sck_oe_o, sck_o, sdo_o}, 3'b100);
    finish(exp);
    cs_n_i <= 1'b1;
    tick(6);
    check(sdo_oe_o, 1'b0);
  endtask : frame_run

  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence: table rows, then reset and awkward cases.
  initial begin
    rst_i = 1'b1;
    cs_n_i = 1'b1;
    res_valid_i = 1'b0;
    res_sign_i = 1'b0;
    res_data_i = 16'h0000;
    drv_low = 1'b0;
    clr = 1'b1;
    addr = 5'h00;
    tick(4);
    check({sck_oe_o, sdo_oe_o, sck_pu_o, conv_start_o}, 4'h2);
    rst_i <= 1'b0;
    clr <= 1'b0;
    wait_start(1, 5'h00);
    check(int_sck_mode_o, 1'b1);
    for (i = 0; i < 4; i++) begin
      give(rows[i].sign, rows[i].data);
      frame_run(rows[i].addr, rows[i].frame);
      wait_start(i + 2, rows[i].addr);
    end
    give(1'b0, 16'h1234);
    cs_n_i <= 1'b0;
    tick(6);
    check(sdo_oe_o, 1'b1);
    cs_n_i <= 1'b1;
    tick(12);
    check({sdo_oe_o, sck_pu_o, sck_w, edges}, 8'h73);
    frame_run(5'h0c, 19'h01234);
    wait_start(6, 5'h0c);
    give(1'b1, 16'h00ff);
    open_frame(5'h07, 1'b0);
    for (k = 0; k < 900 && edges < 5'h02; k++) @(posedge clk_i);
    cs_n_i <= 1'b1;
    wait_start(7, 5'h0c);
    rst_i <= 1'b1;
    cs_n_i <= 1'b0;
    tick(4);
    rst_i <= 1'b0;
    wait_start(1, 5'h00);
    check({int_sck_mode_o, sck_oe_o, sck_o, sdo_o, sdo_oe_o}, 5'h1f);
    open_frame(5'h03, 1'b0);
    give(1'b1, 16'hc3a5);
    finish(19'h1c3a5);
    cs_n_i <= 1'b1;
    drv_low <= 1'b1;
    tick(10);
    cs_n_i <= 1'b0;
    tick(12);
    check({int_sck_mode_o, sck_oe_o, sck_pu_o, sdo_oe_o}, 4'h1);
    report_and_stop();
  end
endmodule : test_adc_internal_clock_serial_port
